// ==== verilog/axis_origin_search_sequencer.sv ====
// One axis of origin search, forced origin, preset and absolute restore.
// Assumes inputs synchronous to aclk except the four field inputs, synced here.
`timescale 1ns/10ps
`include "axis_origin_regs.svh"
module axis_origin_search_sequencer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYC
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire axis_origin_pkg::axil_req_t axi_req,
  output axis_origin_pkg::axil_rsp_t      axi_rsp,
  input  wire logic                       cw_limit_n,
  input  wire logic                       ccw_limit_n,
  input  wire logic                       prox_in,
  input  wire logic                       phase_z,
  input  wire logic [31:0]                enc_pos,
  input  wire logic [31:0]                abs_data,
  input  wire logic                       servo_lock,
  output logic signed [31:0]              speed_cmd,
  output logic                            no_origin,
  output logic                            search_err,
  output logic                            search_busy
);

  generate
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad
      $error("TICK_CYCLES out of range");
    end
  endgenerate

  axis_origin_pkg::seq_t s_ff;
  axis_origin_pkg::seq_t nxt_s;
  axis_origin_pkg::cfg_t cfg;

  logic               cw_act;
  logic               ccw_act;
  logic               prox_act;
  logic               z_rise;
  logic               lim_ahead;
  logic               use_lim;
  logic               detect;
  logic               trig_lvl;
  logic               tick;
  logic               manual;
  logic               start;
  logic               rev_req;
  logic               fail;
  logic               near;
  logic [31:0]        cmd_w;
  logic [31:0]        rd_val;
  logic               rd_hit;
  logic signed [31:0] mag;
  logic signed [31:0] tgt;
  logic signed [31:0] err_pos;
  logic signed [31:0] spd_up;
  logic signed [31:0] spd_dn;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign cfg = s_ff.cfg;

  // ----------------------------------------------------------------
  // Bus handshakes and outputs
  // ----------------------------------------------------------------
  assign axi_rsp.awready = !s_ff.aw_got && !s_ff.bvalid;
  assign axi_rsp.wready  = !s_ff.w_got && !s_ff.bvalid;
  assign axi_rsp.bvalid  = s_ff.bvalid;
  assign axi_rsp.bresp   = s_ff.bresp;
  assign axi_rsp.arready = !s_ff.rvalid;
  assign axi_rsp.rvalid  = s_ff.rvalid;
  assign axi_rsp.rdata   = s_ff.rdata;
  assign axi_rsp.rresp   = s_ff.rresp;
  assign speed_cmd       = s_ff.speed;
  assign no_origin       = s_ff.no_origin;
  assign search_err      = s_ff.err;
  assign search_busy     = s_ff.state != axis_origin_pkg::ST_IDLE;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (axi_req.araddr)
      `A_CTRL:   rd_val = s_ff.ctrl;
      `A_CFG:    rd_val = s_ff.cfg;
      `A_HIRATE: rd_val = s_ff.hirate;
      `A_LORATE: rd_val = s_ff.lorate;
      `A_OFFSET: rd_val = s_ff.offset;
      `A_CMD:    rd_val = 32'h0000_0000;
      `A_PRESET: rd_val = s_ff.preset;
      `A_STAT:   rd_val = {28'h000_0000, s_ff.done, search_busy, s_ff.err, s_ff.no_origin};
      `A_POS:    rd_val = enc_pos - s_ff.origin;
      `A_ABSORG: rd_val = s_ff.abs_org;
      `A_ACCEL:  rd_val = s_ff.accel;
      default:   rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    cmd_w = 32'h0000_0000;
    rev_req = 1'b0;
    fail = 1'b0;

    // Input synchronisers and decoded levels
    nxt_s.s1 = {phase_z, prox_in, ccw_limit_n, cw_limit_n};
    nxt_s.s2 = s_ff.s1;
    nxt_s.prev_z = s_ff.s2[3];
    cw_act = !s_ff.s2[0];
    ccw_act = !s_ff.s2[1];
    prox_act = s_ff.s2[2] ^ cfg.prox_nc;
    z_rise = s_ff.s2[3] && !s_ff.prev_z;
    lim_ahead = s_ff.dir_cw ? cw_act : ccw_act;
    use_lim = cfg.dec_by_limit || !cfg.prox_present;
    detect = use_lim ? lim_ahead : prox_act;
    trig_lvl = use_lim ? (s_ff.trig_cw ? cw_act : ccw_act) : prox_act;
    manual = !cfg.auto_mode;

    // Bus write channel
    if (axi_req.awvalid && axi_rsp.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = axi_req.wdata;
      nxt_s.wstrb = axi_req.wstrb;
    end
    if (s_ff.bvalid && axi_req.bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `RESP_OK;
      unique case (s_ff.awaddr)
        `A_CTRL:   nxt_s.ctrl = merge(s_ff.ctrl, s_ff.wdata, s_ff.wstrb);
        `A_CFG:    nxt_s.cfg = merge(s_ff.cfg, s_ff.wdata, s_ff.wstrb);
        `A_HIRATE: nxt_s.hirate = merge(s_ff.hirate, s_ff.wdata, s_ff.wstrb);
        `A_LORATE: nxt_s.lorate = merge(s_ff.lorate, s_ff.wdata, s_ff.wstrb);
        `A_OFFSET: nxt_s.offset = merge(s_ff.offset, s_ff.wdata, s_ff.wstrb);
        `A_CMD:    cmd_w = merge(32'h0000_0000, s_ff.wdata, s_ff.wstrb);
        `A_PRESET: nxt_s.preset = merge(s_ff.preset, s_ff.wdata, s_ff.wstrb);
        `A_ACCEL:  nxt_s.accel = merge(s_ff.accel, s_ff.wdata, s_ff.wstrb);
        `A_STAT, `A_POS, `A_ABSORG: nxt_s.bresp = `RESP_OK;
        default:   nxt_s.bresp = `RESP_ERR;
      endcase
    end

    // Bus read channel
    if (s_ff.rvalid && axi_req.rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd_val;
      nxt_s.rresp = rd_hit ? `RESP_OK : `RESP_ERR;
    end

    // Control word edges
    nxt_s.prv_srch = s_ff.ctrl[`B_SEARCH];
    nxt_s.prv_force = s_ff.ctrl[`B_FORCE];
    nxt_s.prv_abs = s_ff.ctrl[`B_ABSSET];
    nxt_s.prv_lock = servo_lock;
    start = (manual && s_ff.ctrl[`B_SEARCH] && !s_ff.prv_srch)
         || (!manual && cmd_w[`B_CMD_SRCH]);

    // Profile tick
    tick = s_ff.tick_cnt == 16'(TICK_CYCLES - 1);
    nxt_s.tick_cnt = tick ? 16'h0000 : s_ff.tick_cnt + 16'h0001;

    // Speed target for the current phase
    err_pos = s_ff.target - enc_pos;
    near = (err_pos < 0 ? -err_pos : err_pos) <= $signed(`NEAR_DIST);
    unique case (s_ff.state)
      axis_origin_pkg::ST_HIGH: mag = s_ff.hirate;
      axis_origin_pkg::ST_LOW, axis_origin_pkg::ST_ZWAIT: mag = s_ff.lorate;
      axis_origin_pkg::ST_MOVE: mag = near ? s_ff.lorate : s_ff.hirate;
      default: mag = 32'sh0000_0000;
    endcase
    tgt = s_ff.dir_cw ? mag : -mag;

    // Ramped approach toward the target speed
    spd_up = s_ff.speed + s_ff.accel;
    spd_dn = s_ff.speed - s_ff.accel;
    if (tick) begin
      if (s_ff.speed < tgt) begin
        nxt_s.speed = (spd_up > tgt) ? tgt : spd_up;
      end else if (s_ff.speed > tgt) begin
        nxt_s.speed = (spd_dn < tgt) ? tgt : spd_dn;
      end
    end

    // ----------------------------------------------------------------
    // Search sequence
    // ----------------------------------------------------------------
    unique case (s_ff.state)
      axis_origin_pkg::ST_IDLE: begin
        if (start) begin
          nxt_s.err = 1'b0;
          nxt_s.done = 1'b0;
          nxt_s.rev_cnt = 2'h0;
          nxt_s.no_origin = 1'b1;
          unique case (cfg.method)
            axis_origin_pkg::M_POWER_ON: begin
              nxt_s.target = s_ff.por_pos;
              nxt_s.state = axis_origin_pkg::ST_MOVE;
            end
            axis_origin_pkg::M_REVERSE: begin
              nxt_s.dir_cw = cfg.init_cw;
              nxt_s.state = axis_origin_pkg::ST_HIGH;
            end
            axis_origin_pkg::M_ONE_DIR: begin
              nxt_s.dir_cw = cfg.zdir_cw;
              nxt_s.state = axis_origin_pkg::ST_HIGH;
            end
            default: fail = 1'b1;
          endcase
        end
      end
      axis_origin_pkg::ST_HIGH: begin
        if (detect) begin
          nxt_s.trig_cw = s_ff.dir_cw;
          nxt_s.dir_cw = use_lim ? !s_ff.dir_cw : cfg.zdir_cw;
          nxt_s.state = axis_origin_pkg::ST_LOW;
        end else if (lim_ahead) begin
          rev_req = 1'b1;
        end
      end
      axis_origin_pkg::ST_LOW: begin
        if (!trig_lvl) begin
          nxt_s.state = axis_origin_pkg::ST_ZWAIT;
        end else if (lim_ahead) begin
          rev_req = 1'b1;
        end
      end
      axis_origin_pkg::ST_ZWAIT: begin
        if (z_rise) begin
          nxt_s.speed = 32'sh0000_0000;
          nxt_s.origin = enc_pos;
          if (s_ff.offset != 32'h0000_0000) begin
            nxt_s.target = enc_pos + s_ff.offset;
            nxt_s.state = axis_origin_pkg::ST_MOVE;
          end else begin
            nxt_s.no_origin = 1'b0;
            nxt_s.done = 1'b1;
            nxt_s.state = axis_origin_pkg::ST_IDLE;
          end
        end else if (lim_ahead) begin
          fail = 1'b1;
        end
      end
      axis_origin_pkg::ST_REVSTOP: begin
        if (s_ff.speed == 32'sh0000_0000) begin
          nxt_s.dir_cw = !s_ff.dir_cw;
          nxt_s.state = axis_origin_pkg::ST_HIGH;
        end
      end
      axis_origin_pkg::ST_MOVE: begin
        nxt_s.dir_cw = err_pos > 0;
        if (err_pos == 32'sh0000_0000) begin
          nxt_s.speed = 32'sh0000_0000;
          nxt_s.origin = enc_pos;
          nxt_s.no_origin = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.state = axis_origin_pkg::ST_IDLE;
        end
      end
      default: fail = 1'b1;
    endcase

    // Limit reached while searching
    if (rev_req) begin
      if (cfg.method != axis_origin_pkg::M_REVERSE || s_ff.rev_cnt == `MAX_REV) begin
        fail = 1'b1;
      end else begin
        nxt_s.rev_cnt = s_ff.rev_cnt + 2'h1;
        if (cfg.lim_decel) begin
          nxt_s.state = axis_origin_pkg::ST_REVSTOP;
        end else begin
          nxt_s.speed = 32'sh0000_0000;
          nxt_s.dir_cw = !s_ff.dir_cw;
          nxt_s.state = axis_origin_pkg::ST_HIGH;
        end
      end
    end
    if (fail) begin
      nxt_s.speed = 32'sh0000_0000;
      nxt_s.err = 1'b1;
      nxt_s.no_origin = 1'b1;
      nxt_s.state = axis_origin_pkg::ST_IDLE;
    end

    // ----------------------------------------------------------------
    // Origin set without motion
    // ----------------------------------------------------------------
    if (s_ff.state == axis_origin_pkg::ST_IDLE && !start) begin
      if (manual && s_ff.ctrl[`B_FORCE] && !s_ff.prv_force
          && s_ff.speed == 32'sh0000_0000) begin
        nxt_s.origin = enc_pos;
        nxt_s.no_origin = 1'b0;
      end else if ((manual && cmd_w[`B_CMD_IOW]) || (!manual && cmd_w[`B_CMD_PRE])) begin
        nxt_s.origin = enc_pos - s_ff.preset;
        nxt_s.no_origin = 1'b0;
      end else if (cfg.abs_enc && servo_lock && !s_ff.prv_lock) begin
        nxt_s.origin = enc_pos - abs_data + s_ff.abs_org;
        nxt_s.no_origin = 1'b0;
      end
    end
    if (s_ff.ctrl[`B_ABSSET] && !s_ff.prv_abs) begin
      nxt_s.abs_org = abs_data;
    end

    // First cycle after reset release
    if (!s_ff.por_done) begin
      nxt_s.por_done = 1'b1;
      nxt_s.por_pos = enc_pos;
      if (cfg.method == axis_origin_pkg::M_POWER_ON) begin
        nxt_s.origin = enc_pos;
        nxt_s.no_origin = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.cfg <= `CFG_RST;
      s_ff.hirate <= `HIRATE_RST;
      s_ff.lorate <= `LORATE_RST;
      s_ff.accel <= `ACCEL_RST;
      s_ff.no_origin <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

// ==== verilog/axis_origin_regs.svh ====
// Register offsets, field bits, reset values and timing for the origin sequencer.
// Assumes one 100 MHz clock and a 32-bit AXI4-Lite register port.
`ifndef AXIS_ORIGIN_REGS_SVH
`define AXIS_ORIGIN_REGS_SVH
`define A_CTRL     8'h00
`define A_CFG      8'h04
`define A_HIRATE   8'h08
`define A_LORATE   8'h0c
`define A_OFFSET   8'h10
`define A_CMD      8'h14
`define A_PRESET   8'h18
`define A_STAT     8'h1c
`define A_POS      8'h20
`define A_ABSORG   8'h24
`define A_ACCEL    8'h28
`define B_SEARCH   1
`define B_FORCE    5
`define B_ABSSET   6
`define B_CMD_SRCH 0
`define B_CMD_PRE  1
`define B_CMD_IOW  2
`define CFG_RST    32'h0000_0000
`define HIRATE_RST 32'h0000_0100
`define LORATE_RST 32'h0000_0010
`define ACCEL_RST  32'h0000_0008
`define NEAR_DIST  32'h0000_0040
`define MAX_REV    2'h3
`define RESP_OK    2'h0
`define RESP_ERR   2'h2
`define TICK_NS    1000
`define CLK_NS     10
`define TICK_CYC   ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== verilog/axis_origin_pkg.sv ====
// Types of the origin sequencer: states, configuration, bus carriers, state record.
// Assumes axis_origin_regs.svh on the include path.
`include "axis_origin_regs.svh"
package axis_origin_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_HIGH = 3'h1, ST_LOW = 3'h2,
    ST_ZWAIT = 3'h3, ST_REVSTOP = 3'h4, ST_MOVE = 3'h5
  } seq_state_t;
  typedef enum logic [1:0] {
    M_POWER_ON = 2'h0, M_REVERSE = 2'h1, M_ONE_DIR = 2'h2
  } method_t;
  typedef struct packed {
    logic [21:0] rsvd;
    logic auto_mode, abs_enc, prox_present, prox_nc;
    logic lim_decel, dec_by_limit, init_cw, zdir_cw;
    method_t method;
  } cfg_t;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready, wready, bvalid; logic [1:0] bresp;
    logic arready, rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axil_rsp_t;
  typedef struct packed {
    seq_state_t state; logic dir_cw, trig_cw; logic [1:0] rev_cnt;
    logic signed [31:0] speed; logic [15:0] tick_cnt;
    logic [31:0] origin, por_pos, abs_org, target;
    logic por_done, no_origin, err, done;
    logic [3:0] s1, s2; logic prev_z, prv_srch, prv_force, prv_abs, prv_lock;
    logic [31:0] ctrl; cfg_t cfg; logic [31:0] hirate, lorate, offset, accel, preset;
    logic aw_got, w_got; logic [7:0] awaddr; logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid, rvalid; logic [1:0] bresp, rresp; logic [31:0] rdata;
  } seq_t;
endpackage

// ==== verif/axis_origin_chk.sv ====
// Checker: bus handshake, reset and error properties of the origin sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/10ps
module axis_origin_chk #(
  parameter int unsigned TICK_CYCLES = 100
) (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire axis_origin_pkg::axil_req_t axi_req,
  input wire axis_origin_pkg::axil_rsp_t axi_rsp,
  input wire logic signed [31:0]         speed_cmd,
  input wire logic                       no_origin,
  input wire logic                       search_err,
  input wire logic                       search_busy
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_state: assert property ($rose(aresetn) |->
    speed_cmd == 32'sh0 && no_origin && !search_err && !search_busy)
    else $error("outputs not at reset values");
  a_err_stop: assert property (search_err && !search_busy |-> speed_cmd == 32'sh0)
    else $error("axis moves after search error");
  a_err_noorg: assert property ($rose(search_err) |-> no_origin)
    else $error("error raised with origin kept");
  a_start_noorg: assert property ($rose(search_busy) |-> ##[0:1] no_origin)
    else $error("search start kept origin");
  a_wr_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
    else $error("write answer late");
  a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped");
  a_b_blocks: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answer pending");
  a_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped");
endmodule

bind axis_origin_search_sequencer axis_origin_chk #(.TICK_CYCLES(TICK_CYCLES)) axis_origin_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .speed_cmd(speed_cmd), .no_origin(no_origin), .search_err(search_err),
  .search_busy(search_busy));

// ==== verif/servo_axis_model.sv ====
// Servo driver, encoder and switches: one count of travel per STEP cycles.
// Assumes the speed command sign gives direction, positive is clockwise.
`timescale 1ns/10ps
module servo_axis_model #(
  parameter int STEP   = 8,
  parameter int LIM_HI = 200,
  parameter int LIM_LO = -200,
  parameter int PRX_LO = 100,
  parameter int PRX_HI = 140
) (
  input  wire logic               aclk,
  input  wire logic signed [31:0] speed_cmd,
  input  wire logic               prox_nc,
  input  wire logic               cut_cw,
  output logic [31:0]             enc_pos,
  output logic                    cw_limit_n,
  output logic                    ccw_limit_n,
  output logic                    prox_in,
  output logic                    phase_z
);
  int pos;
  int div;
  initial begin
    pos = 0;
    div = 0;
  end
  always @(posedge aclk) begin
    div <= (div + 1) % STEP;
    if (div == 0 && speed_cmd > 0) pos <= pos + 1;
    else if (div == 0 && speed_cmd < 0) pos <= pos - 1;
  end
  assign enc_pos = 32'(pos);
  // Broken line reads as limit reached
  assign cw_limit_n = !(pos >= LIM_HI || cut_cw);
  assign ccw_limit_n = !(pos <= LIM_LO);
  assign prox_in = (pos >= PRX_LO && pos <= PRX_HI) ^ prox_nc;
  assign phase_z = (pos[3:2] == 2'h0);
endmodule

// ==== verif/axis_origin_search_sequencer_tb.sv ====
// Bench of the origin sequencer: bus tasks, search scenarios and verdict.
// Assumes design files, checker and servo_axis_model are compiled first.
`timescale 1ns/10ps
`include "axis_origin_regs.svh"
module axis_origin_search_sequencer_tb;
  logic                       aclk;
  logic                       aresetn;
  axis_origin_pkg::axil_req_t axi_req;
  axis_origin_pkg::axil_rsp_t axi_rsp;
  logic                       cw_limit_n, ccw_limit_n, prox_in, phase_z;
  logic                       servo_lock, prox_nc, cut_cw;
  logic                       no_origin, search_err, search_busy;
  logic signed [31:0]         speed_cmd;
  logic [31:0]                enc_pos, abs_data, lfsr, a1;
  logic [31:0]                lim_cfg[2] = '{32'h0000_000d, 32'h0000_00dd};
  logic [33:0]                rd_q[$];
  logic [1:0]                 wr_q[$];
  int                         err_count, checks;

  axis_origin_search_sequencer #(.TICK_CYCLES(2)) axis_origin_search_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .cw_limit_n(cw_limit_n), .ccw_limit_n(ccw_limit_n), .prox_in(prox_in),
    .phase_z(phase_z), .enc_pos(enc_pos), .abs_data(abs_data), .servo_lock(servo_lock),
    .speed_cmd(speed_cmd), .no_origin(no_origin), .search_err(search_err),
    .search_busy(search_busy));
  servo_axis_model servo_axis_model_inst (
    .aclk(aclk), .speed_cmd(speed_cmd), .prox_nc(prox_nc), .cut_cw(cut_cw),
    .enc_pos(enc_pos), .cw_limit_n(cw_limit_n), .ccw_limit_n(ccw_limit_n),
    .prox_in(prox_in), .phase_z(phase_z));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // --------------------
  // Tasks
  // --------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp = 2'h0);
    bit ok;
    ok = 1'b0;
    @(posedge aclk);
    wr_q.push_back(rsp);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid && axi_req.bready) begin
        ok = 1'b1;
        break;
      end
      if (axi_rsp.bvalid) axi_req.bready <= 1'b1;
    end
    axi_req.bready <= 1'b0;
    // A write that never answers counts as a mismatch
    if (!ok) begin
      err_count++;
      $display("Error write %h expected answer seen none", a);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp = 2'h0);
    bit ok;
    ok = 1'b0;
    @(posedge aclk);
    rd_q.push_back({rsp, d});
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    for (int n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid && axi_req.rready) begin
        ok = 1'b1;
        break;
      end
      if (axi_rsp.rvalid) axi_req.rready <= 1'b1;
    end
    axi_req.rready <= 1'b0;
    // A read that never answers counts as a mismatch
    if (!ok) begin
      err_count++;
      $display("Error read %h expected answer seen none", a);
    end
  endtask
  task automatic search(input logic [31:0] cfg, input logic [31:0] pos, input logic [1:0] flg);
    wr(`A_CFG, cfg);
    wr(`A_CTRL, 32'h0);
    wr(`A_CTRL, 32'h2);
    for (int n = 0; n < 8 && !search_busy; n++) @(posedge aclk);
    for (int n = 0; n < 9000 && search_busy; n++) @(posedge aclk);
    cmp("position", {2'h0, pos}, {2'h0, enc_pos});
    cmp("speed", 34'h0, {2'h0, speed_cmd});
    cmp("flags", {32'h0, flg}, {31'h0, search_busy, no_origin, search_err});
  endtask
  // Bus answers are checked against the oldest note
  always @(posedge aclk) begin
    if (axi_rsp.rvalid && axi_req.rready)
      cmp("read", rd_q.pop_front(), {axi_rsp.rresp, axi_rsp.rdata});
    if (axi_rsp.bvalid && axi_req.bready)
      cmp("bresp", {32'h0, wr_q.pop_front()}, {32'h0, axi_rsp.bresp});
  end
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
  // --------------------
  // Scenarios
  // --------------------
  initial begin
    axi_req = '0;
    aresetn = 1'b0;
    servo_lock = 1'b0;
    prox_nc = 1'b0;
    cut_cw = 1'b0;
    lfsr = 32'h0000_0039;
    a1 = lfsr;
    abs_data = lfsr;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`A_CFG, `CFG_RST);
    rd(`A_HIRATE, `HIRATE_RST);
    rd(`A_LORATE, `LORATE_RST);
    rd(`A_ACCEL, `ACCEL_RST);
    rd(`A_STAT, 32'h0);
    rd(8'h40, 32'h0, `RESP_ERR);
    wr(8'h40, 32'h1, `RESP_ERR);
    rd(`A_CMD, 32'h0);
    note("reset");
    prox_nc <= 1'b1;
    search(32'h0000_00cd, 32'h0000_0090, 2'h0);
    rd(`A_POS, 32'h0);
    rd(`A_STAT, 32'h8);
    wr(`A_OFFSET, 32'h5);
    search(32'h0000_00ed, 32'h0000_0095, 2'h0);
    rd(`A_POS, 32'h0);
    cut_cw <= 1'b1;
    search(32'h0000_00c6, 32'h0000_0095, 2'h3);
    cut_cw <= 1'b0;
    wr(`A_OFFSET, 32'h0);
    foreach (lim_cfg[i]) search(lim_cfg[i], 32'h0000_00c3, 2'h0);
    // Reverse method with abrupt stop at the clockwise limit
    search(32'h0000_00cd, 32'h0000_0090, 2'h0);
    note("search");
    wr(`A_PRESET, 32'ha);
    wr(`A_CMD, 32'h4);
    rd(`A_POS, 32'ha);
    wr(`A_PRESET, 32'h14);
    wr(`A_CMD, 32'h2);
    rd(`A_POS, 32'ha);
    wr(`A_CFG, 32'h0000_020d);
    wr(`A_CMD, 32'h2);
    rd(`A_POS, 32'h14);
    wr(`A_CTRL, 32'h20);
    rd(`A_POS, 32'h14);
    wr(`A_CFG, 32'h0000_000d);
    wr(`A_CTRL, 32'h0);
    wr(`A_CTRL, 32'h20);
    rd(`A_POS, 32'h0);
    note("preset");
    wr(`A_CTRL, 32'h40);
    rd(`A_ABSORG, a1);
    lfsr = lfsr_step(lfsr);
    abs_data <= lfsr;
    wr(`A_CFG, 32'h0000_010d);
    servo_lock <= 1'b1;
    rd(`A_POS, lfsr - a1);
    note("absolute");
    search(32'h0, 32'h0, 2'h0);
    note("power-on");
    end_of_test();
  end
endmodule
